/* File: core/bmg_pkg.sv */
// constants and types shared by the buck gang configuration block
package bmg_pkg;
  localparam int NUM_CONV = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SETPOINT_W = 8;
  localparam int PHASE_W = 3;
  localparam int GOV_W = 3;
  localparam int GANG_W = 2;

  localparam logic [7:0] OFS_GANG_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONV_BASE = 8'h04;
  localparam logic [7:0] OFS_CONV_END = 8'h1c;

  localparam int CONV_SET_LSB = 0;
  localparam int CONV_PHASE_LSB = 8;
  localparam int ST_FIRST_LSB = 0;
  localparam int ST_FOURTH_LSB = 2;
  localparam int ST_FIFTH_LSB = 4;
  localparam int ST_P4_DUAL_BIT = 6;
  localparam int ST_P5_DUAL_BIT = 7;
  localparam int ST_VALID_BIT = 8;

  localparam logic [2:0] PHASE_RESET = 3'h7;
  localparam logic [7:0] SETPOINT_RESET = 8'h00;
  localparam logic [1:0] GANG_RESET = 2'h0;

  localparam logic [2:0] CONV_ONE = 3'h0;
  localparam logic [2:0] CONV_TWO = 3'h1;
  localparam logic [2:0] CONV_THREE = 3'h2;
  localparam logic [2:0] CONV_FOUR = 3'h3;
  localparam logic [2:0] CONV_FIVE = 3'h4;
  localparam logic [2:0] CONV_SIX = 3'h5;

  typedef enum logic [1:0] {
    BMG_FIRST_SINGLE = 2'b00,
    BMG_FIRST_DUAL = 2'b01,
    BMG_FIRST_QUAD = 2'b10,
    BMG_FIRST_TRIPLE = 2'b11
  } bmg_first_mode_t;

  typedef enum logic [1:0] {
    BMG_PAIR_SINGLE = 2'b00,
    BMG_PAIR_DUAL = 2'b01,
    BMG_PAIR_RSVD_A = 2'b10,
    BMG_PAIR_RSVD_B = 2'b11
  } bmg_pair_mode_t;

  typedef logic [NUM_CONV-1:0][GOV_W-1:0] bmg_gov_vec_t;
endpackage

/* File: core/bmg_conv_bank.sv */
// per-converter register sets: voltage setpoint and phase shift
`timescale 1ns/1ps
`default_nettype none
module bmg_conv_bank #(
  parameter int NUM = 6,
  parameter logic [7:0] SET_RESET = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_setpoint,
  input wire logic [2:0] wr_phase,
  output logic [NUM-1:0][7:0] setpoint,
  output logic [NUM-1:0][2:0] phase
);
  import bmg_pkg::*;

  typedef struct packed {
    logic [NUM-1:0][7:0] setpoint;
    logic [NUM-1:0][2:0] phase;
  } bmg_bank_state_t;

  bmg_bank_state_t state_reg;
  bmg_bank_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (rst) begin
      for (int i = 0; i < NUM; i++) begin
        state_next.setpoint[i] = SET_RESET;
        state_next.phase[i] = PHASE_RESET;
      end
    end else if (wr_en) begin
      state_next.setpoint[wr_idx] = wr_setpoint;
      state_next.phase[wr_idx] = wr_phase;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign setpoint = state_reg.setpoint;
  assign phase = state_reg.phase;
endmodule
`default_nettype wire

/* File: core/bmg_gang_top.sv */
// buck gang decoder with per-converter settings and governing map
// What this block does
// - quad phase: converters one to four follow converter one's settings
// - triple phase: converters one to three follow converter one's settings
// - during triple phase, converter four runs alone on its own settings
// - first pair dual: converters one and two follow converter one
// - first field: 00 single, 01 dual, 10 quad, 11 triple
// - third/fourth pair dual: both follow converter four's settings
// - fourth-pair field: 00 single, 01 dual, 10 and 11 reserved
// - quad or triple on first field overrides the fourth-pair field
// - fifth/sixth pair dual: both follow converter five's settings
// - fifth-pair field: 00 single, 01 dual, 10 and 11 reserved
// - every phase keeps its own phase-shift field, never the master's
// - phase field resets to 111 (zero degrees), writable while running
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bmg_gang_top (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [bmg_pkg::GANG_W-1:0] OTP_FIRST_RAIL_GANG_SELECT,
  input wire logic [bmg_pkg::GANG_W-1:0] OTP_FOURTH_PAIR_GANG_SELECT,
  input wire logic [bmg_pkg::GANG_W-1:0] OTP_FIFTH_PAIR_GANG_SELECT,
  input wire logic [bmg_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [bmg_pkg::DATA_W-1:0] REG_WR_DATA,
  input wire logic REG_WR_STB,
  input wire logic REG_RD_STB,
  output logic [bmg_pkg::DATA_W-1:0] REG_RD_DATA,
  output logic GANG_VALID,
  output logic [bmg_pkg::GANG_W-1:0] FIRST_RAIL_MODE,
  output logic FOURTH_PAIR_DUAL,
  output logic FIFTH_PAIR_DUAL,
  output logic [bmg_pkg::NUM_CONV-1:0][bmg_pkg::GOV_W-1:0] CONV_GOVERNOR,
  output logic [bmg_pkg::NUM_CONV-1:0][bmg_pkg::SETPOINT_W-1:0] CONV_SETPOINT,
  output logic [bmg_pkg::NUM_CONV-1:0][bmg_pkg::PHASE_W-1:0] CONV_PHASE_SHIFT
);
  import bmg_pkg::*;

  typedef struct packed {
    logic loaded;
    logic [GANG_W-1:0] first_sel;
    logic [GANG_W-1:0] fourth_sel;
    logic [GANG_W-1:0] fifth_sel;
    logic gang_valid;
    logic [GANG_W-1:0] rail_mode;
    logic pair4_dual;
    logic pair5_dual;
    logic [NUM_CONV-1:0][GOV_W-1:0] governor;
    logic [NUM_CONV-1:0][SETPOINT_W-1:0] setpoint;
    logic [NUM_CONV-1:0][PHASE_W-1:0] phase;
    logic [DATA_W-1:0] rd_data;
  } bmg_top_state_t;

  bmg_top_state_t state_reg;
  bmg_top_state_t state_next;

  logic [NUM_CONV-1:0][SETPOINT_W-1:0] bank_setpoint;
  logic [NUM_CONV-1:0][PHASE_W-1:0] bank_phase;
  logic [3:0] addr_dec;
  logic bank_wr_en;

  // address to converter slot, msb is hit
  function automatic logic [3:0] conv_slot(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] off;
    logic hit;
    off = addr - OFS_CONV_BASE;
    hit = (addr >= OFS_CONV_BASE) && (addr < OFS_CONV_END) && (addr[1:0] == 2'h0);
    return {hit, off[4:2]};
  endfunction

  // first field sets a rail spanning three or four phases
  function automatic logic wide_first(input logic [GANG_W-1:0] sel);
    return (sel == BMG_FIRST_QUAD) || (sel == BMG_FIRST_TRIPLE);
  endfunction

  // effective dual on a pair, reserved codes fall to single
  function automatic logic pair_dual(input logic [GANG_W-1:0] sel);
    return sel == BMG_PAIR_DUAL;
  endfunction

  // which converter's register set governs each converter
  function automatic bmg_gov_vec_t gov_map(
    input logic [GANG_W-1:0] first,
    input logic p4_dual,
    input logic p5_dual
  );
    bmg_gov_vec_t g;
    g[0] = CONV_ONE;
    g[1] = CONV_TWO;
    g[2] = CONV_THREE;
    g[3] = CONV_FOUR;
    g[4] = CONV_FIVE;
    g[5] = CONV_SIX;
    unique case (first)
      BMG_FIRST_SINGLE: begin
        g[1] = CONV_TWO;
      end
      BMG_FIRST_DUAL: begin
        g[1] = CONV_ONE;
      end
      BMG_FIRST_QUAD: begin
        g[1] = CONV_ONE;
        g[2] = CONV_ONE;
        g[3] = CONV_ONE;
      end
      BMG_FIRST_TRIPLE: begin
        g[1] = CONV_ONE;
        g[2] = CONV_ONE;
        g[3] = CONV_FOUR;
      end
    endcase
    if (p4_dual) begin
      g[2] = CONV_FOUR;
    end
    if (p5_dual) begin
      g[5] = CONV_FIVE;
    end
    return g;
  endfunction

  assign addr_dec = conv_slot(REG_ADDR);
  assign bank_wr_en = REG_WR_STB && addr_dec[3];

  bmg_conv_bank #(
    .NUM(NUM_CONV),
    .SET_RESET(SETPOINT_RESET)
  ) u_bank (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .wr_en(bank_wr_en),
    .wr_idx(addr_dec[2:0]),
    .wr_setpoint(REG_WR_DATA[CONV_SET_LSB +: SETPOINT_W]),
    .wr_phase(REG_WR_DATA[CONV_PHASE_LSB +: PHASE_W]),
    .setpoint(bank_setpoint),
    .phase(bank_phase)
  );

  always_comb begin
    state_next = state_reg;
    state_next.rd_data = '0;
    if (SYS_RST) begin
      state_next.loaded = 1'b0;
      state_next.first_sel = GANG_RESET;
      state_next.fourth_sel = GANG_RESET;
      state_next.fifth_sel = GANG_RESET;
      state_next.gang_valid = 1'b0;
      state_next.rail_mode = GANG_RESET;
      state_next.pair4_dual = 1'b0;
      state_next.pair5_dual = 1'b0;
      for (int i = 0; i < NUM_CONV; i++) begin
        state_next.governor[i] = 3'(i);
        state_next.setpoint[i] = SETPOINT_RESET;
        state_next.phase[i] = PHASE_RESET;
      end
    end else begin
      if (!state_reg.loaded) begin
        state_next.loaded = 1'b1;
        state_next.first_sel = OTP_FIRST_RAIL_GANG_SELECT;
        state_next.fourth_sel = OTP_FOURTH_PAIR_GANG_SELECT;
        state_next.fifth_sel = OTP_FIFTH_PAIR_GANG_SELECT;
      end
      state_next.gang_valid = state_reg.loaded;
      state_next.rail_mode = state_reg.first_sel;
      state_next.pair4_dual = !wide_first(state_reg.first_sel) &&
                              pair_dual(state_reg.fourth_sel);
      state_next.pair5_dual = pair_dual(state_reg.fifth_sel);
      state_next.governor = gov_map(state_reg.first_sel,
                                    !wide_first(state_reg.first_sel) &&
                                    pair_dual(state_reg.fourth_sel),
                                    pair_dual(state_reg.fifth_sel));
      for (int i = 0; i < NUM_CONV; i++) begin
        state_next.setpoint[i] = bank_setpoint[state_reg.governor[i]];
        state_next.phase[i] = bank_phase[i];
      end
      if (REG_RD_STB) begin
        if (REG_ADDR == OFS_GANG_STATUS) begin
          state_next.rd_data[ST_FIRST_LSB +: GANG_W] = state_reg.first_sel;
          state_next.rd_data[ST_FOURTH_LSB +: GANG_W] = state_reg.fourth_sel;
          state_next.rd_data[ST_FIFTH_LSB +: GANG_W] = state_reg.fifth_sel;
          state_next.rd_data[ST_P4_DUAL_BIT] = state_reg.pair4_dual;
          state_next.rd_data[ST_P5_DUAL_BIT] = state_reg.pair5_dual;
          state_next.rd_data[ST_VALID_BIT] = state_reg.gang_valid;
        end else if (addr_dec[3]) begin
          state_next.rd_data[CONV_SET_LSB +: SETPOINT_W] = bank_setpoint[addr_dec[2:0]];
          state_next.rd_data[CONV_PHASE_LSB +: PHASE_W] = bank_phase[addr_dec[2:0]];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    state_reg <= state_next;
  end

  assign REG_RD_DATA = state_reg.rd_data;
  assign GANG_VALID = state_reg.gang_valid;
  assign FIRST_RAIL_MODE = state_reg.rail_mode;
  assign FOURTH_PAIR_DUAL = state_reg.pair4_dual;
  assign FIFTH_PAIR_DUAL = state_reg.pair5_dual;
  assign CONV_GOVERNOR = state_reg.governor;
  assign CONV_SETPOINT = state_reg.setpoint;
  assign CONV_PHASE_SHIFT = state_reg.phase;
endmodule
`default_nettype wire

/* File: bench/bmg_gang_checker.sv */
// assertions on the gang decode outputs of the buck gang block
`timescale 1ns/1ps
`default_nettype none
module bmg_gang_checker (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic GANG_VALID,
  input wire logic [bmg_pkg::GANG_W-1:0] FIRST_RAIL_MODE,
  input wire logic FOURTH_PAIR_DUAL,
  input wire logic FIFTH_PAIR_DUAL,
  input wire logic [bmg_pkg::NUM_CONV-1:0][bmg_pkg::GOV_W-1:0] CONV_GOVERNOR
);
  import bmg_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_quad;
    GANG_VALID && FIRST_RAIL_MODE == 2'h2 |-> CONV_GOVERNOR[3:0] == 12'h0;
  endproperty
  a_quad: assert property (p_quad) else $error("quad map wrong");
  property p_triple;
    GANG_VALID && FIRST_RAIL_MODE == 2'h3 |-> CONV_GOVERNOR[2:0] == 9'h0;
  endproperty
  a_triple: assert property (p_triple) else $error("triple map wrong");
  property p_alone;
    GANG_VALID && FIRST_RAIL_MODE == 2'h3 |-> CONV_GOVERNOR[3] == 3'h3;
  endproperty
  a_alone: assert property (p_alone) else $error("fourth not alone");
  property p_dual1;
    GANG_VALID && FIRST_RAIL_MODE == 2'h1 |-> CONV_GOVERNOR[1:0] == 6'h0;
  endproperty
  a_dual1: assert property (p_dual1) else $error("first pair map wrong");
  property p_single;
    GANG_VALID && FIRST_RAIL_MODE == 2'h0 |-> CONV_GOVERNOR[1:0] == 6'h8;
  endproperty
  a_single: assert property (p_single) else $error("single map wrong");
  property p_pair4;
    FOURTH_PAIR_DUAL |-> CONV_GOVERNOR[3:2] == 6'h1b;
  endproperty
  a_pair4: assert property (p_pair4) else $error("fourth pair map wrong");
  property p_over;
    GANG_VALID && FIRST_RAIL_MODE[1] |-> !FOURTH_PAIR_DUAL;
  endproperty
  a_over: assert property (p_over) else $error("override lost");
  property p_pair5;
    GANG_VALID |-> CONV_GOVERNOR[5:4] == (FIFTH_PAIR_DUAL ? 6'h24 : 6'h2c);
  endproperty
  a_pair5: assert property (p_pair5) else $error("fifth pair map wrong");
  property p_hold;
    GANG_VALID |=> GANG_VALID && $stable(FIRST_RAIL_MODE) && $stable(CONV_GOVERNOR);
  endproperty
  a_hold: assert property (p_hold) else $error("gang changed");
endmodule
bind bmg_gang_top bmg_gang_checker u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .GANG_VALID(GANG_VALID), .FIRST_RAIL_MODE(FIRST_RAIL_MODE),
  .FOURTH_PAIR_DUAL(FOURTH_PAIR_DUAL), .FIFTH_PAIR_DUAL(FIFTH_PAIR_DUAL),
  .CONV_GOVERNOR(CONV_GOVERNOR));
`default_nettype wire

/* File: bench/tb_bmg_gang_top.sv */
// self-checking bench for the buck gang configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_bmg_gang_top;
  import bmg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] of = 2'h0, o4 = 2'h0, o5 = 2'h0, mode;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic ws = 1'b0, rs = 1'b0, valid, p4d, p5d;
  bmg_gov_vec_t gov;
  logic [47:0] setp;
  logic [17:0] phs;
  int num_errors = 0;
  int checks = 0;
  always #5 clk = ~clk;
  bmg_gang_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .OTP_FIRST_RAIL_GANG_SELECT(of),
    .OTP_FOURTH_PAIR_GANG_SELECT(o4), .OTP_FIFTH_PAIR_GANG_SELECT(o5), .REG_ADDR(addr),
    .REG_WR_DATA(wd), .REG_WR_STB(ws), .REG_RD_STB(rs), .REG_RD_DATA(rdata),
    .GANG_VALID(valid), .FIRST_RAIL_MODE(mode), .FOURTH_PAIR_DUAL(p4d), .FIFTH_PAIR_DUAL(p5d),
    .CONV_GOVERNOR(gov), .CONV_SETPOINT(setp), .CONV_PHASE_SHIFT(phs));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic [1:0] f, a, b, input int n);
    rst <= 1'b1;
    of <= f;
    o4 <= a;
    o5 <= b;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic bmg_gov_vec_t exp_gov(input logic [1:0] f, a, b);
    bmg_gov_vec_t g;
    g = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    if (f != 2'h0) g[1] = 3'h0;
    if (f[1]) g[2] = 3'h0;
    if (f == 2'h2) g[3] = 3'h0;
    if (!f[1] && a == 2'h1) g[2] = 3'h3;
    if (b == 2'h1) g[5] = 3'h4;
    return g;
  endfunction
  task automatic test_regs();
    logic [31:0] d;
    do_reset(2'h0, 2'h0, 2'h0, 20);
    @(negedge clk);
    chk(48'(phs), 48'h3ffff);
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd(OFS_CONV_BASE + 8'(4 * i), d);
      chk(48'(d), 48'h700);
    end
    @(negedge clk);
    chk(48'(rdata), 48'h0);
    @(posedge clk);
    rd(8'h20, d);
    chk(48'(d), 48'h0);
    wr(OFS_CONV_BASE + 8'h01, 32'h155);
    wr(OFS_CONV_END, 32'h155);
    rd(OFS_CONV_BASE, d);
    chk(48'(d), 48'h700);
    wr(OFS_GANG_STATUS, 32'h1ff);
    rd(OFS_GANG_STATUS, d);
    chk(48'(d), 48'h100);
    $display("test_regs done");
  endtask
  task automatic test_decode();
    logic [31:0] d;
    logic x4;
    logic x5;
    for (int f = 0; f < 4; f++) begin
      for (int a = 0; a < 4; a++) begin
        for (int b = 0; b < 4; b++) begin
          do_reset(2'(f), 2'(a), 2'(b), 2);
          x4 = (f < 2) && (a == 1);
          x5 = (b == 1);
          @(negedge clk);
          chk(48'(gov), 48'(exp_gov(2'(f), 2'(a), 2'(b))));
          chk(48'({p4d, p5d, mode, valid}), 48'({x4, x5, 2'(f), 1'b1}));
          @(posedge clk);
          rd(OFS_GANG_STATUS, d);
          chk(48'(d), 48'({1'b1, b == 1, x4, 2'(b), 2'(a), 2'(f)}));
        end
      end
    end
    $display("test_decode done");
  endtask
  task automatic test_follow(input logic [1:0] f, a, b);
    bmg_gov_vec_t g;
    logic [47:0] sp;
    logic [31:0] d;
    do_reset(f, a, b, 2);
    of <= ~f;
    o4 <= ~a;
    o5 <= ~b;
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CONV_BASE + 8'(4 * i), 32'(i * 256 + 16 + i));
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    g = exp_gov(f, a, b);
    for (int i = 0; i < 6; i++) sp[8 * i +: 8] = 8'h10 + 8'(g[i]);
    chk(48'(phs), 48'({3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}));
    chk(setp, sp);
    chk(48'(gov), 48'(g));
    @(posedge clk);
    rd(OFS_CONV_BASE + 8'h04, d);
    chk(48'(d), 48'h111);
    $display("test_follow done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    $display("Error at %0t: run timed out", $time);
    final_report();
  end
  initial begin
    test_regs();
    test_decode();
    test_follow(2'h2, 2'h1, 2'h1);
    test_follow(2'h3, 2'h1, 2'h0);
    test_follow(2'h1, 2'h1, 2'h3);
    final_report();
  end
endmodule
`default_nettype wire
